// file: design/pfc_pkg.sv
/*
  constants shared by the pause and priority flow control configuration block:
  register offsets, field positions, reset values and timing counts.
  assumes a byte-addressed register port with one 32-bit word per register.
*/
package pfc_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] PFC_OFS_SETUP  = 8'h00;  // pause_control_setup
  localparam logic [7:0] PFC_OFS_STATUS = 8'h04;  // live state, read only

  // ==========================================================================
  // pause_control_setup fields
  localparam int PFC_B_LINK_TX   = 30;
  localparam int PFC_B_LINK_RX   = 29;
  localparam int PFC_B_PRIO_TX   = 26;
  localparam int PFC_B_PRIO_RX   = 25;
  localparam int PFC_B_AUTO_RES  = 20;
  localparam int PFC_B_TXEN_LSB  = 8;
  localparam int PFC_B_RXEN_LSB  = 0;
  localparam int PFC_PRIOS       = 8;

  // reset values with and without priority support
  localparam logic [31:0] PFC_RST_FULL  = 32'h6010_ffff;
  localparam logic [31:0] PFC_RST_LINK  = 32'h6000_0000;
  // writable bits with and without priority support
  localparam logic [31:0] PFC_WMSK_FULL = 32'h6610_ffff;
  localparam logic [31:0] PFC_WMSK_LINK = 32'h6000_0000;

  // ==========================================================================
  // status register fields
  localparam int PFC_S_TX_HOLD   = 0;
  localparam int PFC_S_REQ_BUSY  = 1;
  localparam int PFC_S_CFG_WAIT  = 2;
  localparam int PFC_S_RXV_LSB   = 8;

  // ==========================================================================
  // timing: one pause quantum is 512 bit times; clock is 50 MHz (20 ns)
  localparam int PFC_CLK_NS       = 20;
  localparam int PFC_QUANTUM_NS   = 512;    // 512 bit times at 1 ns per bit
  localparam int PFC_QUANTUM_CYC  = (PFC_QUANTUM_NS + PFC_CLK_NS - 1) / PFC_CLK_NS;
  localparam int PFC_QW           = 16;     // quanta field width

  typedef enum logic [1:0] {
    PFC_TX_IDLE = 2'b00,
    PFC_TX_REQ  = 2'b01
  } pfc_tx_state_e;

endpackage

// file: design/pfc_timer_if.sv
/*
  carrier between the configuration top and one pause timer.
  assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
interface pfc_timer_if;
  logic                       load;    // one-cycle load strobe
  logic [pfc_pkg::PFC_QW-1:0] quanta;  // quanta to run, zero clears
  logic                       clear;   // abort the running pause
  logic                       busy;    // pause in force

  modport ctl (output load, output quanta, output clear, input busy);
  modport tmr (input load, input quanta, input clear, output busy);
endinterface

// file: design/pfc_pause_timer.sv
/*
  one pause timer: counts a number of pause quanta down in ref_clk cycles.
  assumes load, quanta and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module pfc_pause_timer #(
  parameter int QCYC = pfc_pkg::PFC_QUANTUM_CYC
) (
  input  wire logic   ref_clk,
  input  wire logic   srst,
  pfc_timer_if.tmr    tif
);
  import pfc_pkg::*;

  logic [PFC_QW-1:0] quanta_left;
  logic [15:0]       sub_cnt;

  // ==========================================================================
  // countdown: a zero-quanta load ends the pause at once
  always_ff @(posedge ref_clk) begin
    if (srst || tif.clear) begin
      quanta_left <= '0;
      sub_cnt     <= '0;
    end else if (tif.load) begin
      quanta_left <= tif.quanta;
      sub_cnt     <= 16'(QCYC - 1);
    end else if (quanta_left != '0) begin
      if (sub_cnt == 16'h0000) begin
        quanta_left <= quanta_left - 1'b1;
        sub_cnt     <= 16'(QCYC - 1);
      end else begin
        sub_cnt <= sub_cnt - 1'b1;
      end
    end
  end

  assign tif.busy = (quanta_left != '0);
endmodule

// file: design/pfc_flow_cfg.sv
/*
  pause and priority flow control configuration and gating for a 1G MAC.
  decides which client requests become transmitted control frames and how
  received control frames throttle the transmitter or reach the client.
  assumes client, mac transmit and mac receive logic all run on ref_clk.
*/
// Local design decisions: the register addresses and the plain strobed port.
// Functional notes
// - link pause tx enabled: client pause trigger sends one control frame
// - link pause tx disabled: client pause trigger ignored, no frame
// - link pause rx enabled: received pause frames hold transmitter for quanta
// - link pause rx disabled: received pause frames go to client, no hold
// - priority tx enabled: enabled priority request valid sends a priority frame
// - priority tx disabled: all priority request valid inputs ignored
// - priority rx enabled: received frame drives enabled, addressed priority valids
// - priority rx disabled: priority frames not acted on, passed to client
// - auto resume set: released enabled request sends zero-quanta frame
// - without priority support those bits reset to zero and do not exist
// - tx priority enable bits: both request edges send a priority frame
// - rx priority 7 enable: valid quanta for priority 7 drive its valid
// - rx priority 7 enable clear holds priority 7 valid at zero
// - rx priority 6 enable gates priority 6 like priority 7
// - rx priority 5..0 enables gate alike, reset to one with support
`timescale 1ns/1ps
module pfc_flow_cfg #(
  parameter bit PFC_SUPPORT = 1'b1,
  parameter int QCYC        = pfc_pkg::PFC_QUANTUM_CYC
) (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // register port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  // client requests
  input  wire logic                        pause_req,
  input  wire logic                        tx_prio0_pause_valid,
  input  wire logic                        tx_prio1_pause_valid,
  input  wire logic                        tx_prio2_pause_valid,
  input  wire logic                        tx_prio3_pause_valid,
  input  wire logic                        tx_prio4_pause_valid,
  input  wire logic                        tx_prio5_pause_valid,
  input  wire logic                        tx_prio6_pause_valid,
  input  wire logic                        tx_prio7_pause_valid,
  // control frame requests to the mac transmitter
  output logic                             tx_fc_req,
  output logic                             tx_fc_pfc,
  output logic      [pfc_pkg::PFC_PRIOS-1:0] tx_fc_class,
  output logic      [pfc_pkg::PFC_PRIOS-1:0] tx_fc_zero,
  input  wire logic                        tx_fc_ack,
  output logic                             tx_pause_hold,
  // received control frames from the mac receiver
  input  wire logic                        rx_fc_busy,
  input  wire logic                        rx_fc_frame,
  input  wire logic                        rx_fc_pfc,
  input  wire logic [pfc_pkg::PFC_PRIOS-1:0] rx_fc_class,
  input  wire logic [127:0]                rx_fc_quanta,
  output logic                             rx_fc_forward,
  output logic                             rx_prio0_pause_valid,
  output logic                             rx_prio1_pause_valid,
  output logic                             rx_prio2_pause_valid,
  output logic                             rx_prio3_pause_valid,
  output logic                             rx_prio4_pause_valid,
  output logic                             rx_prio5_pause_valid,
  output logic                             rx_prio6_pause_valid,
  output logic                             rx_prio7_pause_valid
);
  import pfc_pkg::*;

  localparam logic [31:0] RST_VAL = PFC_SUPPORT ? PFC_RST_FULL : PFC_RST_LINK;
  localparam logic [31:0] WR_MSK  = PFC_SUPPORT ? PFC_WMSK_FULL : PFC_WMSK_LINK;

  logic [31:0]           setup_sw;    // value software sees
  logic [31:0]           setup_act;   // value the logic obeys
  logic                  at_boundary;
  logic                  link_tx_en;
  logic                  link_rx_en;
  logic                  prio_tx_en;
  logic                  prio_rx_en;
  logic                  auto_res;
  logic [PFC_PRIOS-1:0]  tx_prio_en;
  logic [PFC_PRIOS-1:0]  rx_prio_en;
  logic [PFC_PRIOS-1:0]  prio_req;
  logic [PFC_PRIOS-1:0]  prio_req_d;
  logic                  pause_req_d;
  logic [PFC_PRIOS-1:0]  new_rise;
  logic [PFC_PRIOS-1:0]  new_fall;
  logic                  new_lon;
  logic                  new_loff;
  logic [PFC_PRIOS-1:0]  pend_rise;
  logic [PFC_PRIOS-1:0]  pend_fall;
  logic                  pend_lon;
  logic                  pend_loff;
  logic                  issue;
  logic                  issue_link;
  pfc_tx_state_e         tx_state;
  pfc_tx_state_e         next_tx_state;
  logic [PFC_PRIOS-1:0]  prio_busy;
  logic [PFC_PRIOS-1:0]  rx_valid;

  pfc_timer_if tif [PFC_PRIOS+1] ();

  // quanta slot i of a received frame
  function automatic logic [PFC_QW-1:0] slot_q(input logic [127:0] q, input int i);
    slot_q = q[i*PFC_QW +: PFC_QW];
  endfunction

  // ==========================================================================
  // register file
  // boundary: no control frame waiting to go out and none being received
  assign at_boundary = (tx_state == PFC_TX_IDLE) && !rx_fc_busy;

  // software copy; bits that do not exist in a link-only build stay zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      setup_sw <= RST_VAL;
    end else if (reg_wr && reg_addr == PFC_OFS_SETUP) begin
      setup_sw <= reg_wdata & WR_MSK;
    end
  end

  // working copy follows the software copy only between frames
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      setup_act <= RST_VAL;
    end else if (at_boundary) begin
      setup_act <= setup_sw;
    end
  end

  // read data stand in the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        PFC_OFS_SETUP:  reg_rdata <= setup_sw;
        PFC_OFS_STATUS: begin
          reg_rdata                                 <= 32'h0000_0000;
          reg_rdata[PFC_S_TX_HOLD]                  <= tx_pause_hold;
          reg_rdata[PFC_S_REQ_BUSY]                 <= tx_fc_req;
          reg_rdata[PFC_S_CFG_WAIT]                 <= (setup_sw != setup_act);
          reg_rdata[PFC_S_RXV_LSB +: PFC_PRIOS]     <= rx_valid;
        end
        default:        reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // field decode of the working copy
  assign link_tx_en = setup_act[PFC_B_LINK_TX];
  assign link_rx_en = setup_act[PFC_B_LINK_RX];
  assign prio_tx_en = setup_act[PFC_B_PRIO_TX];
  assign prio_rx_en = setup_act[PFC_B_PRIO_RX];
  assign auto_res   = setup_act[PFC_B_AUTO_RES];
  assign tx_prio_en = setup_act[PFC_B_TXEN_LSB +: PFC_PRIOS];
  assign rx_prio_en = setup_act[PFC_B_RXEN_LSB +: PFC_PRIOS];

  // ==========================================================================
  // transmit requests
  assign prio_req = {tx_prio7_pause_valid, tx_prio6_pause_valid, tx_prio5_pause_valid,
                     tx_prio4_pause_valid, tx_prio3_pause_valid, tx_prio2_pause_valid,
                     tx_prio1_pause_valid, tx_prio0_pause_valid};

  // previous levels for edge detection
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prio_req_d  <= '0;
      pause_req_d <= 1'b0;
    end else begin
      prio_req_d  <= prio_req;
      pause_req_d <= pause_req;
    end
  end

  // edges that may cause a frame under the present enables
  assign new_lon  = link_tx_en & pause_req & ~pause_req_d;
  assign new_loff = link_tx_en & auto_res & ~pause_req & pause_req_d;
  assign new_rise = {PFC_PRIOS{prio_tx_en}} & tx_prio_en & prio_req & ~prio_req_d;
  assign new_fall = {PFC_PRIOS{prio_tx_en}} & tx_prio_en & ~prio_req & prio_req_d;

  assign issue      = (tx_state == PFC_TX_IDLE) &&
                      (pend_lon || pend_loff || pend_rise != '0 || pend_fall != '0);
  assign issue_link = pend_lon || pend_loff;

  // pending edges; a new edge wins over the clear of the one being issued
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_lon  <= 1'b0;
      pend_loff <= 1'b0;
      pend_rise <= '0;
      pend_fall <= '0;
    end else begin
      if (!link_tx_en) begin
        pend_lon  <= 1'b0;
        pend_loff <= 1'b0;
      end else if (issue && issue_link) begin
        pend_lon  <= new_lon;
        pend_loff <= new_loff;
      end else begin
        pend_lon  <= pend_lon | new_lon;
        pend_loff <= pend_loff | new_loff;
      end
      if (!prio_tx_en) begin
        pend_rise <= '0;
        pend_fall <= '0;
      end else if (issue && !issue_link) begin
        pend_rise <= new_rise;
        pend_fall <= new_fall;
      end else begin
        pend_rise <= pend_rise | new_rise;
        pend_fall <= pend_fall | new_fall;
      end
    end
  end

  // request handshake with the transmitter
  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      PFC_TX_IDLE: if (issue) next_tx_state = PFC_TX_REQ;
      PFC_TX_REQ:  if (tx_fc_ack) next_tx_state = PFC_TX_IDLE;
      default:     next_tx_state = PFC_TX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_state <= PFC_TX_IDLE;
    end else begin
      tx_state <= next_tx_state;
    end
  end

  // frame contents captured when the request is raised
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_fc_pfc   <= 1'b0;
      tx_fc_class <= '0;
      tx_fc_zero  <= '0;
    end else if (issue) begin
      if (issue_link) begin
        tx_fc_pfc   <= 1'b0;
        tx_fc_class <= '0;
        tx_fc_zero  <= {{(PFC_PRIOS-1){1'b0}}, ~pend_lon};
      end else begin
        tx_fc_pfc   <= 1'b1;
        tx_fc_class <= pend_rise | (pend_fall & {PFC_PRIOS{auto_res}});
        tx_fc_zero  <= pend_fall & ~pend_rise & {PFC_PRIOS{auto_res}};
      end
    end
  end

  assign tx_fc_req = (tx_state == PFC_TX_REQ);

  // ==========================================================================
  // receive side: timer 0..7 per priority, timer 8 for link pause
  genvar gi;
  generate
    for (gi = 0; gi <= PFC_PRIOS; gi++) begin : g_tmr
      pfc_pause_timer #(
        .QCYC (QCYC)
      ) u_tmr (
        .ref_clk (ref_clk),
        .srst    (srst),
        .tif     (tif[gi])
      );
    end
    for (gi = 0; gi < PFC_PRIOS; gi++) begin : g_prio
      assign tif[gi].load   = rx_fc_frame & rx_fc_pfc & prio_rx_en &
                              rx_fc_class[gi] & rx_prio_en[gi];
      assign tif[gi].quanta = slot_q(rx_fc_quanta, gi);
      assign tif[gi].clear  = ~prio_rx_en | ~rx_prio_en[gi];
      assign prio_busy[gi]  = tif[gi].busy;
    end
  endgenerate

  // link pause loads from quanta slot 0
  assign tif[PFC_PRIOS].load   = rx_fc_frame & ~rx_fc_pfc & link_rx_en;
  assign tif[PFC_PRIOS].quanta = slot_q(rx_fc_quanta, 0);
  assign tif[PFC_PRIOS].clear  = ~link_rx_en;

  // registered indications; enable bits gate them to zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_valid      <= '0;
      tx_pause_hold <= 1'b0;
    end else begin
      rx_valid      <= prio_busy & rx_prio_en & {PFC_PRIOS{prio_rx_en}};
      tx_pause_hold <= tif[PFC_PRIOS].busy & link_rx_en;
    end
  end

  // frames not consumed here are passed up to the client
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_fc_forward <= 1'b0;
    end else begin
      rx_fc_forward <= rx_fc_frame &
                       (rx_fc_pfc ? ~prio_rx_en : ~link_rx_en);
    end
  end

  assign rx_prio0_pause_valid = rx_valid[0];
  assign rx_prio1_pause_valid = rx_valid[1];
  assign rx_prio2_pause_valid = rx_valid[2];
  assign rx_prio3_pause_valid = rx_valid[3];
  assign rx_prio4_pause_valid = rx_valid[4];
  assign rx_prio5_pause_valid = rx_valid[5];
  assign rx_prio6_pause_valid = rx_valid[6];
  assign rx_prio7_pause_valid = rx_valid[7];

endmodule

// file: sim/pfc_mac_model.sv
/*
  mac transmitter stand-in: takes control frame requests after a set delay.
  assumes the block under test on ref_clk; lat is set by the bench.
*/
`timescale 1ns/1ps
module pfc_mac_model (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       tx_fc_req,
  input  wire logic       tx_fc_pfc,
  input  wire logic [7:0] tx_fc_class,
  input  wire logic [7:0] tx_fc_zero,
  input  wire logic [3:0] lat,
  output logic            tx_fc_ack,
  output logic      [7:0] frm_cnt,
  output logic            frm_pfc,
  output logic      [7:0] frm_class,
  output logic      [7:0] frm_zero
);
  logic [3:0] wait_cnt;

  // ==========================================================================
  // take the request after lat idle cycles, log what was sent
  always_ff @(posedge ref_clk) begin
    if (srst || tx_fc_ack || !tx_fc_req) begin
      tx_fc_ack <= 1'b0;
      wait_cnt  <= 4'h0;
    end else if (wait_cnt == lat) begin
      tx_fc_ack <= 1'b1;
      frm_pfc   <= tx_fc_pfc;
      frm_class <= tx_fc_class;
      frm_zero  <= tx_fc_zero;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // count taken frames
  always_ff @(posedge ref_clk) begin
    if (srst) frm_cnt <= 8'h00;
    else if (tx_fc_req && !tx_fc_ack && wait_cnt == lat) frm_cnt <= frm_cnt + 8'h01;
  end
endmodule

// file: sim/pfc_flow_cfg_props.sv
/*
  port assertions for the pause configuration block.
  assumes one clock ref_clk and synchronous srst; bound onto pfc_flow_cfg.
*/
`timescale 1ns/1ps
module pfc_flow_cfg_props (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        tx_fc_req,
  input wire logic        tx_fc_pfc,
  input wire logic [7:0]  tx_fc_class,
  input wire logic [7:0]  tx_fc_zero,
  input wire logic        tx_fc_ack,
  input wire logic        tx_pause_hold,
  input wire logic        rx_fc_frame,
  input wire logic        rx_fc_forward,
  input wire logic        rx_prio6_pause_valid,
  input wire logic        rx_prio7_pause_valid
);
  import pfc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // ==========================================================================
  // outputs quiet out of reset, requests held, causes of indications
  rst_quiet_a: assert property ($fell(srst) |-> !tx_fc_req && !tx_pause_hold)
    else $error("outputs active after reset");
  req_hold_a: assert property (tx_fc_req && !tx_fc_ack |=> tx_fc_req && $stable(tx_fc_class)
    && $stable(tx_fc_zero) && $stable(tx_fc_pfc)) else $error("request changed before ack");
  req_done_a: assert property (tx_fc_req && tx_fc_ack |=> !tx_fc_req)
    else $error("request kept after ack");
  zero_pair_a: assert property (tx_fc_req && tx_fc_pfc |-> (tx_fc_zero & ~tx_fc_class) == 8'h00)
    else $error("zero quanta on class not enabled");
  fwd_cause_a: assert property (rx_fc_forward |-> $past(rx_fc_frame))
    else $error("forward without frame");
  hold_cause_a: assert property ($rose(tx_pause_hold) |-> $past(rx_fc_frame, 2))
    else $error("hold without frame");
  prio7_cause_a: assert property ($rose(rx_prio7_pause_valid) |-> $past(rx_fc_frame, 2))
    else $error("prio7 valid without frame");
  prio6_cause_a: assert property ($rose(rx_prio6_pause_valid) |-> $past(rx_fc_frame, 2))
    else $error("prio6 valid without frame");
  unmap_rd_a: assert property (reg_rd && reg_addr > PFC_OFS_STATUS |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");

  // main scenarios
  c_ack: cover property (tx_fc_req && tx_fc_ack);
  c_fwd: cover property (rx_fc_forward);
  c_hold: cover property ($rose(tx_pause_hold));
endmodule

bind pfc_flow_cfg pfc_flow_cfg_props chk_u (
  .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_fc_req(tx_fc_req), .tx_fc_pfc(tx_fc_pfc), .tx_fc_class(tx_fc_class),
  .tx_fc_zero(tx_fc_zero), .tx_fc_ack(tx_fc_ack), .tx_pause_hold(tx_pause_hold),
  .rx_fc_frame(rx_fc_frame), .rx_fc_forward(rx_fc_forward),
  .rx_prio6_pause_valid(rx_prio6_pause_valid), .rx_prio7_pause_valid(rx_prio7_pause_valid)
);

// file: sim/test_pfc_flow_cfg.sv
/*
  testbench for the pause configuration block: register, tx and rx scenarios.
  assumes pfc_mac_model acks requests; QCYC shortened to 2.
*/
`timescale 1ns/1ps
module test_pfc_flow_cfg;
  import pfc_pkg::*;
  logic         ref_clk, srst, reg_wr, reg_rd, pause_req, rx_fc_busy, rx_fc_frame, rx_fc_pfc;
  logic         tx_fc_req, tx_fc_pfc, tx_fc_ack, tx_pause_hold, rx_fc_forward, frm_pfc;
  logic [7:0]   reg_addr, tx_pv, rx_fc_class, rxv, tx_fc_class, tx_fc_zero;
  logic [7:0]   frm_cnt, frm_class, frm_zero;
  logic [3:0]   lat;
  logic [31:0]  reg_wdata, reg_rdata, lnk_rdata;
  logic [127:0] rx_fc_quanta;
  int           n_errors, n_checks;

  pfc_flow_cfg #(.PFC_SUPPORT(1'b1), .QCYC(2)) dut_u (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pause_req(pause_req),
    .tx_prio0_pause_valid(tx_pv[0]), .tx_prio1_pause_valid(tx_pv[1]),
    .tx_prio2_pause_valid(tx_pv[2]), .tx_prio3_pause_valid(tx_pv[3]),
    .tx_prio4_pause_valid(tx_pv[4]), .tx_prio5_pause_valid(tx_pv[5]),
    .tx_prio6_pause_valid(tx_pv[6]), .tx_prio7_pause_valid(tx_pv[7]),
    .tx_fc_req(tx_fc_req), .tx_fc_pfc(tx_fc_pfc), .tx_fc_class(tx_fc_class),
    .tx_fc_zero(tx_fc_zero), .tx_fc_ack(tx_fc_ack), .tx_pause_hold(tx_pause_hold),
    .rx_fc_busy(rx_fc_busy), .rx_fc_frame(rx_fc_frame), .rx_fc_pfc(rx_fc_pfc),
    .rx_fc_class(rx_fc_class), .rx_fc_quanta(rx_fc_quanta), .rx_fc_forward(rx_fc_forward),
    .rx_prio0_pause_valid(rxv[0]), .rx_prio1_pause_valid(rxv[1]),
    .rx_prio2_pause_valid(rxv[2]), .rx_prio3_pause_valid(rxv[3]),
    .rx_prio4_pause_valid(rxv[4]), .rx_prio5_pause_valid(rxv[5]),
    .rx_prio6_pause_valid(rxv[6]), .rx_prio7_pause_valid(rxv[7])
  );

  // link-only build: only its register contents are compared; its requests are taken at once
  pfc_flow_cfg #(.PFC_SUPPORT(1'b0), .QCYC(2)) lnk_u (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(lnk_rdata), .pause_req(pause_req),
    .tx_prio0_pause_valid(tx_pv[0]), .tx_prio1_pause_valid(tx_pv[1]),
    .tx_prio2_pause_valid(tx_pv[2]), .tx_prio3_pause_valid(tx_pv[3]),
    .tx_prio4_pause_valid(tx_pv[4]), .tx_prio5_pause_valid(tx_pv[5]),
    .tx_prio6_pause_valid(tx_pv[6]), .tx_prio7_pause_valid(tx_pv[7]),
    .tx_fc_req(), .tx_fc_pfc(), .tx_fc_class(), .tx_fc_zero(), .tx_fc_ack(1'b1),
    .tx_pause_hold(), .rx_fc_busy(rx_fc_busy), .rx_fc_frame(rx_fc_frame),
    .rx_fc_pfc(rx_fc_pfc), .rx_fc_class(rx_fc_class), .rx_fc_quanta(rx_fc_quanta),
    .rx_fc_forward(), .rx_prio0_pause_valid(), .rx_prio1_pause_valid(),
    .rx_prio2_pause_valid(), .rx_prio3_pause_valid(), .rx_prio4_pause_valid(),
    .rx_prio5_pause_valid(), .rx_prio6_pause_valid(), .rx_prio7_pause_valid()
  );

  pfc_mac_model mac_u (
    .ref_clk(ref_clk), .srst(srst), .tx_fc_req(tx_fc_req), .tx_fc_pfc(tx_fc_pfc),
    .tx_fc_class(tx_fc_class), .tx_fc_zero(tx_fc_zero), .lat(lat), .tx_fc_ack(tx_fc_ack),
    .frm_cnt(frm_cnt), .frm_pfc(frm_pfc), .frm_class(frm_class), .frm_zero(frm_zero)
  );

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // register write, then room for the working copy to update
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // set client requests; check frames sent and, masked, the last one's contents
  task automatic txe(input logic lk, input logic [7:0] pv, input int dn, input logic [31:0] m,
                     input logic [31:0] e);
    logic [7:0] c0;
    c0 = frm_cnt;
    @(posedge ref_clk);
    pause_req <= lk;
    tx_pv     <= pv;
    repeat (16) @(posedge ref_clk);
    chk(32'(frm_cnt - c0), dn);
    if (dn != 0) chk({15'h0, frm_pfc, frm_class, frm_zero} & m, e);
  endtask

  // one received frame; check forward, then {hold, valids} on and off
  task automatic rxe(input logic pf, input logic [7:0] cl, input logic fw, input logic [8:0] ev);
    @(posedge ref_clk);
    rx_fc_frame  <= 1'b1;
    rx_fc_pfc    <= pf;
    rx_fc_class  <= cl;
    rx_fc_quanta <= {8{16'h0003}};
    @(posedge ref_clk);
    rx_fc_frame  <= 1'b0;
    rx_fc_pfc    <= ~pf;
    rx_fc_class  <= ~cl;
    rx_fc_quanta <= ~{8{16'h0003}};
    #1 chk(rx_fc_forward, fw);
    @(posedge ref_clk);
    #1 chk({tx_pause_hold, rxv}, ev);
    repeat (20) @(posedge ref_clk);
    chk({tx_pause_hold, rxv}, 9'h0);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    wrap_up();
  end

  // ==========================================================================
  // test sequence; software never sets link and priority modes together
  initial begin
    srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    pause_req = 1'b0; tx_pv = 8'h00; rx_fc_busy = 1'b0; rx_fc_frame = 1'b0;
    rx_fc_pfc = 1'b0; rx_fc_class = 8'h00; rx_fc_quanta = 128'h0; lat = 4'h0;
    n_errors = 0; n_checks = 0;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    rd(PFC_OFS_SETUP, PFC_RST_FULL);
    chk(lnk_rdata, PFC_RST_LINK);
    rd(8'h08, 32'h0);
    wr(PFC_OFS_SETUP, 32'h9e6f_ffff);
    rd(PFC_OFS_SETUP, 32'h0600_ffff);
    chk(lnk_rdata, 32'h0000_0000);
    $display("test registers done");
    wr(PFC_OFS_SETUP, 32'h6010_0000);
    txe(1'b1, 8'h00, 1, 32'h100ff, 32'h0);
    lat <= 4'h5;
    txe(1'b0, 8'h00, 1, 32'h10001, 32'h1);
    rxe(1'b0, 8'h00, 1'b0, 9'h100);
    wr(PFC_OFS_SETUP, 32'h0000_0000);
    txe(1'b1, 8'h00, 0, 32'h0, 32'h0);
    txe(1'b0, 8'h00, 0, 32'h0, 32'h0);
    rxe(1'b0, 8'h00, 1'b1, 9'h000);
    $display("test link pause done");
    wr(PFC_OFS_SETUP, 32'h0610_7fff);
    for (int i = 0; i < 8; i++) begin
      lat <= 4'(i);
      txe(1'b0, 8'h01 << i, (i < 7) ? 1 : 0, 32'h1ffff, {15'h1, 8'h01 << i, 8'h00});
      txe(1'b0, 8'h00, (i < 7) ? 1 : 0, 32'h1ffff, {15'h1, 8'h01 << i, 8'h01 << i});
    end
    rx_fc_busy <= 1'b1;
    wr(PFC_OFS_SETUP, 32'h0210_ff00);
    rd(PFC_OFS_STATUS, 32'h0000_0004);
    txe(1'b0, 8'h01, 1, 32'h1ffff, 32'h10100);
    rx_fc_busy <= 1'b0;
    repeat (3) @(posedge ref_clk);
    txe(1'b0, 8'h00, 0, 32'h0, 32'h0);
    txe(1'b0, 8'h02, 0, 32'h0, 32'h0);
    $display("test priority tx done");
    wr(PFC_OFS_SETUP, 32'h0210_00ff);
    rxe(1'b1, 8'hc0, 1'b0, 9'h0c0);
    wr(PFC_OFS_SETUP, 32'h0210_007f);
    rxe(1'b1, 8'hc0, 1'b0, 9'h040);
    wr(PFC_OFS_SETUP, 32'h0210_00bf);
    rxe(1'b1, 8'h7f, 1'b0, 9'h03f);
    wr(PFC_OFS_SETUP, 32'h0010_00ff);
    rxe(1'b1, 8'hc0, 1'b1, 9'h000);
    $display("test priority rx done");
    wrap_up();
  end
endmodule
